// ### bench/svr_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "svr_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// controller side of the register port, never stalls
module svr_ctrl_model (
  input  wire logic                   CORE_CLK,
  input  wire logic [15:0]            RDATA,
  output var logic  [`SVR_ADDR_W-1:0] ADDR,
  output var logic  [15:0]            WDATA,
  output var logic                    WR,
  output var logic                    RD
);
  initial begin
    ADDR = '0;
    WDATA = '0;
    WR = 1'b0;
    RD = 1'b0;
  end

  // released lines show inverted values so a stale word is never reused
  task automatic bus_wr(input logic [`SVR_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask

  // read data stands one cycle only, taken just after the strobe edge
  task automatic bus_rd(input logic [`SVR_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    ADDR <= ~a;
    #1 d = RDATA;
    // hand back on an edge so callers drive stimulus there
    @(posedge CORE_CLK);
  endtask
endmodule // svr_ctrl_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "svr_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, (e), (g)); end end
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  import svr_pkg::*;
  // short millisecond keeps the 60 ms timeout at 120 cycles
  localparam int unsigned MS_C = 2;
  logic                   CORE_CLK;
  logic                   ARST_N;
  logic [`SVR_ADDR_W-1:0] ADDR;
  logic [15:0]            WDATA;
  logic                   WR;
  logic                   RD;
  logic [15:0]            RDATA;
  logic [7:0]             SEV_ERR_IN;
  logic                   INT_ERR;
  logic                   DL_DONE;
  svr_cfg_s               CFG;
  logic                   ERR_PRESENT;
  logic                   SEV_FATAL;
  logic                   BUF_CTRL;
  logic                   IRQ;
  int                     err_count;
  int                     compares;

  svr_regs #(.MS_CYCLES(MS_C)) dut_u (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SEV_ERR_IN(SEV_ERR_IN),
    .INT_ERR(INT_ERR), .DL_DONE(DL_DONE), .CFG(CFG), .ERR_PRESENT(ERR_PRESENT),
    .SEV_FATAL(SEV_FATAL), .BUF_CTRL(BUF_CTRL), .IRQ(IRQ));
  svr_ctrl_model ctrl_u (.CORE_CLK(CORE_CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD));

  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [`SVR_ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] d;
    ctrl_u.bus_rd(a, d);
    `CHK("rdata", e, d)
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    stop_test();
  end

  initial begin
    err_count = 0;
    compares = 0;
    ARST_N = 1'b0;
    SEV_ERR_IN = 8'h00;
    INT_ERR = 1'b0;
    DL_DONE = 1'b0;
    repeat (8) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    rd_chk(`SVR_ADDR_CFG, 16'h0000);
    rd_chk(`SVR_ADDR_SEV, 16'h0000);
    // all ones: unused bits and the summary bit must stay clear
    ctrl_u.bus_wr(`SVR_ADDR_CFG, 16'hffff);
    #1 `CHK("cfg", 8'hff, CFG)
    rd_chk(`SVR_ADDR_CFG, 16'he01f);
    for (int c = 0; c < 8; c++) begin
      ctrl_u.bus_wr(`SVR_ADDR_CFG, 16'(c << 2) | 16'h0001);
      rd_chk(`SVR_ADDR_CFG, 16'(c << 2) | 16'h0001);
    end
    @(posedge CORE_CLK);
    INT_ERR <= 1'b1;
    rd_chk(`SVR_ADDR_CFG, 16'h001f);
    INT_ERR <= 1'b0;
    // mask open before the timeout so the interrupt rises with it
    ctrl_u.bus_wr(`SVR_ADDR_IRQ_MASK, 16'h0007);
    // idle with code 7: 60 ms times MS_C cycles until timeout
    ctrl_u.bus_wr(`SVR_ADDR_CFG, 16'h001d);
    repeat (100) @(posedge CORE_CLK);
    #1 `CHK("err early", 1'b0, ERR_PRESENT)
    repeat (30) @(posedge CORE_CLK);
    #1 `CHK("err late", 1'b1, ERR_PRESENT)
    rd_chk(`SVR_ADDR_IRQ_STAT, 16'h0001);
    #1 `CHK("irq on", 1'b1, IRQ)
    ctrl_u.bus_wr(`SVR_ADDR_IRQ_STAT, 16'h0001);
    #1 `CHK("irq off", 1'b0, IRQ)
    ctrl_u.bus_wr(`SVR_ADDR_CFG, 16'h0000);
    // severe causes: memory device bit alone leaves the summary clear
    SEV_ERR_IN <= 8'h80;
    repeat (8) @(posedge CORE_CLK);
    #1 `CHK("sfe", 1'b0, SEV_FATAL)
    rd_chk(`SVR_ADDR_SEV, 16'h0100);
    rd_chk(`SVR_ADDR_CFG, 16'h0000);
    SEV_ERR_IN <= 8'h7f;
    repeat (8) @(posedge CORE_CLK);
    SEV_ERR_IN <= 8'h00;
    repeat (8) @(posedge CORE_CLK);
    #1 `CHK("sfe", 1'b1, SEV_FATAL)
    rd_chk(`SVR_ADDR_SEV, 16'h017f);
    rd_chk(`SVR_ADDR_CFG, 16'h0080);
    ctrl_u.bus_wr(`SVR_ADDR_SEV, 16'hffff);
    rd_chk(`SVR_ADDR_SEV, 16'h017f);
    `CHK("buf", 1'b1, BUF_CTRL)
    ctrl_u.bus_wr(5'h1f, 16'hffff);
    rd_chk(5'h1f, 16'h0000);
    // download request held until done pulse
    ctrl_u.bus_wr(`SVR_ADDR_CFG, 16'h8000);
    rd_chk(`SVR_ADDR_CFG, 16'h8080);
    @(posedge CORE_CLK);
    DL_DONE <= 1'b1;
    @(posedge CORE_CLK);
    DL_DONE <= 1'b0;
    rd_chk(`SVR_ADDR_CFG, 16'h0080);
    rd_chk(`SVR_ADDR_IRQ_STAT, 16'h0006);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire

// ### rtl/svr_comm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "svr_consts.svh"

module svr_comm_timer #(
  parameter int unsigned MS_CYCLES = `SVR_MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic       kick,
  input  wire logic [2:0] code,
  output logic            expired
);
  import svr_pkg::*;

  svr_tmr_s r;
  svr_tmr_s next_r;

  function automatic logic [15:0] tmo_ms(input logic [2:0] c);
    case (c)
      3'h0:    tmo_ms = `SVR_TMO0_MS;
      3'h1:    tmo_ms = `SVR_TMO1_MS;
      3'h2:    tmo_ms = `SVR_TMO2_MS;
      3'h3:    tmo_ms = `SVR_TMO3_MS;
      3'h4:    tmo_ms = `SVR_TMO4_MS;
      3'h5:    tmo_ms = `SVR_TMO5_MS;
      3'h6:    tmo_ms = `SVR_TMO6_MS;
      default: tmo_ms = `SVR_TMO7_MS;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // any bus access restarts the watch; flag holds until traffic resumes
  always_comb begin
    next_r = r;
    if (!run || kick) begin
      next_r.pre     = 32'h0;
      next_r.ms      = 16'h0;
      next_r.expired = 1'b0;
    end else if (!r.expired) begin
      if (r.pre == 32'(MS_CYCLES - 1)) begin
        next_r.pre = 32'h0;
        if (r.ms == tmo_ms(code) - 16'h1) begin
          next_r.ms      = 16'h0;
          next_r.expired = 1'b1;
        end else begin
          next_r.ms = r.ms + 16'h1;
        end
      end else begin
        next_r.pre = r.pre + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign expired = r.expired;

  a_tmo_cleared_by_kick: assert property (@(posedge clk) disable iff (!arst_n)
    kick |=> !expired) else $error("timeout flag survived a bus access");

endmodule // svr_comm_timer

`default_nettype wire

// ### rtl/svr_consts.svh
`ifndef SVR_CONSTS_SVH
`define SVR_CONSTS_SVH

// word addresses on the register port
`define SVR_ADDR_W         5
`define SVR_ADDR_CFG       5'h0d
`define SVR_ADDR_SEV       5'h0e
`define SVR_ADDR_IRQ_STAT  5'h10
`define SVR_ADDR_IRQ_MASK  5'h11

// configuration / status word fields
`define SVR_B_CONFIGURED   0
`define SVR_B_ERROR        1
`define SVR_B_TMO_LO       2
`define SVR_B_TMO_HI       4
`define SVR_B_SFE          7
`define SVR_B_CH1_CONT     13
`define SVR_B_CH2_CONT     14
`define SVR_B_DL_REQ       15

// severe error word fields
`define SVR_SEV_W          9
`define SVR_SEV_SUM_HI     6
`define SVR_B_BUF_CTRL     12

// interrupt status / mask fields
`define SVR_IRQ_W          3
`define SVR_IRQ_TMO        0
`define SVR_IRQ_SEV        1
`define SVR_IRQ_DL_DONE    2

// reset values
`define SVR_CFG_RST        16'h0000
`define SVR_IRQ_MASK_RST   3'h0

// timing
`define SVR_CLK_PERIOD_NS  10
`define SVR_MS_CYCLES      ((1000000 + `SVR_CLK_PERIOD_NS - 1) / `SVR_CLK_PERIOD_NS)
`define SVR_TMO0_MS        16'd16000
`define SVR_TMO1_MS        16'd4000
`define SVR_TMO2_MS        16'd2000
`define SVR_TMO3_MS        16'd1000
`define SVR_TMO4_MS        16'd500
`define SVR_TMO5_MS        16'd250
`define SVR_TMO6_MS        16'd120
`define SVR_TMO7_MS        16'd60

`endif

// ### rtl/svr_pkg.sv
`default_nettype none
package svr_pkg;

  typedef struct packed {
    logic       dl_req;
    logic       ch2_cont;
    logic       ch1_cont;
    logic [2:0] tmo_code;
    logic       force_err;
    logic       configured;
  } svr_cfg_s;

  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] ms;
    logic        expired;
  } svr_tmr_s;

  typedef struct packed {
    svr_cfg_s    cfg;
    logic        buf_ctrl;
    logic [8:0]  sev;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic [7:0]  s3;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        tmo_d;
    logic [15:0] rdata;
  } svr_regs_s;

endpackage

`default_nettype wire

// ### rtl/svr_regs.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "svr_consts.svh"

// Behaviour
// - word 13 write loads configuration; read of word 13 returns status
// - config bit 0 configures module; status bit 0 shows configured
// - config bit 1 forces error; status bit 1 is internal, forced or timeout error
// - bits 2-4 timeout code 16 s down to 60 ms, read back
// - status bit 7 is OR of severe error bits 0-6
// - bits 13 and 14 are channel 1 and 2 contingency, both views
// - bit 15 is constants download request, same place both views
// - word 14 reports severe causes; bit 0 EEPROM, bit 1 PROM; writes only load buffer control bit 12
// - severe bits 2-6 readback, logic, serial, diagnostic; bit 8 memory device
module svr_regs #(
  parameter int unsigned MS_CYCLES = `SVR_MS_CYCLES
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   ARST_N,
  input  wire logic [`SVR_ADDR_W-1:0] ADDR,
  input  wire logic [15:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [15:0]            RDATA,
  input  wire logic [7:0]             SEV_ERR_IN,
  input  wire logic                   INT_ERR,
  input  wire logic                   DL_DONE,
  output var svr_pkg::svr_cfg_s       CFG,
  output logic                        ERR_PRESENT,
  output logic                        SEV_FATAL,
  output logic                        BUF_CTRL,
  output logic                        IRQ
);
  import svr_pkg::*;

  svr_regs_s   r;
  svr_regs_s   next_r;
  logic        tmo_expired;
  logic        wr_cfg;
  logic        wr_sev;
  logic        rd_cfg;
  logic        rd_sev;
  logic        err_now;
  logic [8:0]  sev_seen;
  logic [2:0]  ev;
  logic [2:0]  irq_clr;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [`SVR_ADDR_W-1:0] a,
                               input logic [`SVR_ADDR_W-1:0] want);
    hit = (a == want);
  endfunction

  // pin 7 feeds severe bit 8; severe bit 7 has no source
  function automatic logic [8:0] sev_map(input logic [7:0] p);
    sev_map = {p[7], 1'b0, p[6:0]};
  endfunction

  function automatic logic [15:0] status_word(input svr_cfg_s c,
                                              input logic     err,
                                              input logic     severe_fatal_summary);
    logic [15:0] w;
    w                                 = 16'h0000;
    w[`SVR_B_CONFIGURED]              = c.configured;
    w[`SVR_B_ERROR]                   = err;
    w[`SVR_B_TMO_HI:`SVR_B_TMO_LO]    = c.tmo_code;
    w[`SVR_B_SFE]                     = severe_fatal_summary;
    w[`SVR_B_CH1_CONT]                = c.ch1_cont;
    w[`SVR_B_CH2_CONT]                = c.ch2_cont;
    w[`SVR_B_DL_REQ]                  = c.dl_req;
    status_word                       = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  assign wr_cfg  = WR && hit(ADDR, `SVR_ADDR_CFG);
  assign wr_sev  = WR && hit(ADDR, `SVR_ADDR_SEV);
  assign rd_cfg  = RD && hit(ADDR, `SVR_ADDR_CFG);
  assign rd_sev  = RD && hit(ADDR, `SVR_ADDR_SEV);
  assign err_now = r.cfg.force_err | INT_ERR | tmo_expired;

  // a bit is taken only once the two late sync stages agree
  assign sev_seen = sev_map(r.s3 & ~(r.s2 ^ r.s3));

  assign ev[`SVR_IRQ_TMO]     = tmo_expired & ~r.tmo_d;
  assign ev[`SVR_IRQ_SEV]     = |(sev_seen & ~r.sev);
  assign ev[`SVR_IRQ_DL_DONE] = DL_DONE & r.cfg.dl_req;
  assign irq_clr = (WR && hit(ADDR, `SVR_ADDR_IRQ_STAT)) ? WDATA[`SVR_IRQ_W-1:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // watchdog on controller traffic

  svr_comm_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .run     (r.cfg.configured),
    .kick    (WR || RD),
    .code    (r.cfg.tmo_code),
    .expired (tmo_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r       = r;
    next_r.s1    = SEV_ERR_IN;
    next_r.s2    = r.s1;
    next_r.s3    = r.s2;
    next_r.tmo_d = tmo_expired;
    // severe causes latch; only reset clears them, bus writes cannot
    next_r.sev   = r.sev | sev_seen;

    // firmware done pulse drops the request
    if (DL_DONE) begin
      next_r.cfg.dl_req = 1'b0;
    end
    if (wr_cfg) begin
      next_r.cfg.configured = WDATA[`SVR_B_CONFIGURED];
      next_r.cfg.force_err  = WDATA[`SVR_B_ERROR];
      next_r.cfg.tmo_code   = WDATA[`SVR_B_TMO_HI:`SVR_B_TMO_LO];
      next_r.cfg.ch1_cont   = WDATA[`SVR_B_CH1_CONT];
      next_r.cfg.ch2_cont   = WDATA[`SVR_B_CH2_CONT];
      // a write in the done cycle wins over the done pulse
      next_r.cfg.dl_req     = WDATA[`SVR_B_DL_REQ];
    end
    if (wr_sev) begin
      next_r.buf_ctrl = WDATA[`SVR_B_BUF_CTRL];
    end
    if (WR && hit(ADDR, `SVR_ADDR_IRQ_MASK)) begin
      next_r.irq_mask = WDATA[`SVR_IRQ_W-1:0];
    end
    // set beats clear so no event is lost
    next_r.irq_stat = (r.irq_stat & ~irq_clr) | ev;

    next_r.rdata = 16'h0000;
    if (RD) begin
      unique case (1'b1)
        hit(ADDR, `SVR_ADDR_CFG): begin
          next_r.rdata = status_word(r.cfg, err_now, |r.sev[`SVR_SEV_SUM_HI:0]);
        end
        hit(ADDR, `SVR_ADDR_SEV): begin
          next_r.rdata = {7'h00, r.sev};
        end
        hit(ADDR, `SVR_ADDR_IRQ_STAT): begin
          next_r.rdata = {13'h0000, r.irq_stat};
        end
        hit(ADDR, `SVR_ADDR_IRQ_MASK): begin
          next_r.rdata = {13'h0000, r.irq_mask};
        end
        default: begin
          next_r.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r          <= '0;
      r.cfg      <= svr_cfg_s'(`SVR_CFG_RST);
      r.irq_mask <= `SVR_IRQ_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign RDATA       = r.rdata;
  assign CFG         = r.cfg;
  assign ERR_PRESENT = err_now;
  assign SEV_FATAL   = |r.sev[`SVR_SEV_SUM_HI:0];
  assign BUF_CTRL    = r.buf_ctrl;
  assign IRQ         = |(r.irq_stat & r.irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_cfg_write;
    WR && ADDR == `SVR_ADDR_CFG;
  endsequence

  sequence s_cfg_read;
    RD && ADDR == `SVR_ADDR_CFG;
  endsequence

  sequence s_dl_set;
    WR && ADDR == `SVR_ADDR_CFG && WDATA[`SVR_B_DL_REQ];
  endsequence

  a_cfg_write_load: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_write |=> CFG.configured == $past(WDATA[0]) && CFG.force_err == $past(WDATA[1]))
    else $error("config write not loaded");

  a_cfg_read_config: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[0] == $past(CFG.configured))
    else $error("configured bit wrong on read");

  a_cfg_read_error: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[1] == $past(CFG.force_err | INT_ERR | tmo_expired))
    else $error("error bit wrong on read");

  a_force_err_shown: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_write ##0 WDATA[1] |=> ERR_PRESENT)
    else $error("forced error not shown");

  // the master may leave one idle cycle between a write and its read-back
  a_tmo_readback: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_write ##1 !WR ##1 s_cfg_read |=> RDATA[4:2] == $past(WDATA[4:2], 3))
    else $error("timeout code not read back");

  a_sfe_summary: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[7] == |$past(r.sev[6:0]))
    else $error("summary bit not OR of causes");

  a_cont_bits: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_write ##1 !WR ##1 s_cfg_read |=> RDATA[14:13] == $past(WDATA[14:13], 3))
    else $error("contingency bits not read back");

  // a done pulse one cycle on may drop the request legally
  a_dl_set_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_dl_set ##1 (!DL_DONE && !WR) |=> CFG.dl_req)
    else $error("download request not held");

  a_dl_done_clear: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    DL_DONE && !WR |=> !CFG.dl_req)
    else $error("download request not dropped");

  a_sev_read: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    RD && ADDR == `SVR_ADDR_SEV |=> RDATA == {7'h00, $past(r.sev)})
    else $error("severe word read wrong");

  a_sev_sticky: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (r.sev & $past(r.sev)) == $past(r.sev))
    else $error("severe cause lost");

  a_sev_filter: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(r.sev[8]) |-> $past(r.s2[7]) && $past(r.s3[7]))
    else $error("severe bit 8 taken without agreement");

  a_sev_bit7_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !r.sev[7])
    else $error("severe bit 7 set");

  a_unused_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[12:8] == 5'h00 && RDATA[6:5] == 2'h0)
    else $error("unused status bits not zero");

  a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(r.irq_stat[0]) && r.irq_mask[0] |-> IRQ)
    else $error("unmasked event without interrupt");

  a_rdata_idle_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !RD |=> RDATA == 16'h0000)
    else $error("read data outside read cycle");

  a_status_dl_bit: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[15] == $past(CFG.dl_req))
    else $error("download request bit wrong on read");

  a_status_cont: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[14:13] == $past({CFG.ch2_cont, CFG.ch1_cont}))
    else $error("contingency bits wrong on read");

  a_status_tmo: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_read |=> RDATA[4:2] == $past(CFG.tmo_code))
    else $error("timeout code wrong on read");

  a_cfg_unused_void: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_cfg_write |=> CFG == $past({WDATA[15:13], WDATA[4:0]}))
    else $error("config write used unused bits");

  a_sev_write_void: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    WR && ADDR == `SVR_ADDR_SEV |=> r.sev == ($past(r.sev) | $past(sev_seen)))
    else $error("severe word changed by write");

  a_buf_ctrl_load: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    WR && ADDR == `SVR_ADDR_SEV |=> BUF_CTRL == $past(WDATA[`SVR_B_BUF_CTRL]))
    else $error("buffer control not loaded");

  // an idle unconfigured module must never report a lost controller
  a_unconfig_no_tmo: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !CFG.configured |=> !tmo_expired)
    else $error("timeout while unconfigured");

  a_dl_write_wins: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_dl_set ##0 DL_DONE |=> CFG.dl_req)
    else $error("done pulse beat a new request");

  a_irq_set_wins: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ev[`SVR_IRQ_TMO] |=> r.irq_stat[`SVR_IRQ_TMO])
    else $error("timeout event lost");

endmodule // svr_regs

`default_nettype wire
